//--- hw/dswc_config.sv
// display source and warp writeback configuration register bank
// Operation
// - fetch height is 11 bits: low byte plus three low bits of next.
// - virtual width gives the line stride used by the fetcher.
// - camera writer idle flags read 0 busy, 1 idle; idle at reset.
// - blend writeback and warp writeback idle flags, same sense.
// - input two takes blend two on 0, blend one on 1.
// - input one: 00 blend one, 01 warp, 10 fetcher, 11 reserved.
// - vertical flip 1 writes warp lines in reverse order.
// - mode and flip apply only while warp writeback is enabled; flip also needs tiled mode off.
// - writing 1 to warp trigger processes one more warp frame.
// - writing 1 to blend trigger stores one more blend frame.
// - manual blend writeback frame never switches main frame buffer; the switch is held off only in the trigger pulse cycle.
// - pixel format gives bpp: 010 24, 001 16, 000 8.
`timescale 1ns/1ps
`default_nettype none
module dswc_config (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // register port
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // writer busy pins from other clock domains
  input wire logic CAM_ONE_BUSY,
  input wire logic CAM_TWO_BUSY,
  input wire logic BLEND_WB_BUSY,
  input wire logic WARP_WB_BUSY,
  // fetch geometry
  output logic [10:0] FETCH_HEIGHT,
  output logic [10:0] FETCH_VWIDTH,
  output logic [4:0] FETCH_BPP,
  output logic [16:0] FETCH_STRIDE_BYTES,
  // display input routing
  output dswc_pkg::dswc_feed_t DISPLAY_INPUT_ONE,
  output dswc_pkg::dswc_feed_t DISPLAY_INPUT_TWO,
  output dswc_pkg::dswc_feed_t OVERLAY_DISPLAY_INPUT,
  output logic ROUTE_ILLEGAL,
  // warp writeback
  output logic WARP_WB_ENABLE,
  output logic WARP_WB_TILED,
  output logic WARP_WB_VFLIP,
  output logic [31:0] WARP_WB_BUF0_ADDR,
  output logic WARP_TRIGGER,
  output logic BLEND_WB_TRIGGER,
  output logic MAIN_BUFFER_SWITCH_OK,
  // interrupt
  output logic IRQ
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] height_low;
  logic [2:0] height_high;
  logic [7:0] vwidth_low;
  logic [2:0] vwidth_high;
  logic [2:0] pixel_format;
  logic [1:0] sel_one;
  logic sel_two;
  logic sel_overlay;
  logic warp_tiled;
  logic warp_enable;
  logic warp_vflip;
  logic [31:0] buf0_addr;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] busy_meta;
  logic [3:0] busy_sync;
  logic [3:0] busy_prev;
  logic [3:0] frame_done;
  logic [7:0] next_rdata;
  logic [7:0] source_readback;
  logic [7:0] control_readback;

  // register writes; reserved bits of the high bytes are dropped
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      height_low <= dswc_pkg::RST_FETCH_HEIGHT_LOW;
      height_high <= dswc_pkg::RST_FETCH_HEIGHT_HIGH[2:0];
      vwidth_low <= dswc_pkg::RST_FETCH_VWIDTH_LOW;
      vwidth_high <= dswc_pkg::RST_FETCH_VWIDTH_HIGH[2:0];
      pixel_format <= dswc_pkg::RST_FETCH_PIXEL_FORMAT[2:0];
    end
    else if (WR)
    begin
      unique case (ADDR)
        dswc_pkg::OFS_FETCH_HEIGHT_LOW: height_low <= WDATA;
        dswc_pkg::OFS_FETCH_HEIGHT_HIGH: height_high <= WDATA[dswc_pkg::FLD_HEIGHT_HIGH_MSB:0];
        dswc_pkg::OFS_FETCH_VWIDTH_LOW: vwidth_low <= WDATA;
        dswc_pkg::OFS_FETCH_VWIDTH_HIGH: vwidth_high <= WDATA[dswc_pkg::FLD_VWIDTH_HIGH_MSB:0];
        dswc_pkg::OFS_FETCH_PIXEL_FORMAT: pixel_format <= WDATA[2:0];
        default: ;
      endcase
    end
  end

  // routing selection register
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      sel_one <= dswc_pkg::RST_DISPLAY_INPUT_SOURCE[1:0];
      sel_two <= dswc_pkg::RST_DISPLAY_INPUT_SOURCE[dswc_pkg::FLD_SRC_TWO];
      sel_overlay <= dswc_pkg::RST_DISPLAY_INPUT_SOURCE[dswc_pkg::FLD_SRC_OVERLAY];
    end
    else if (WR && ADDR == dswc_pkg::OFS_DISPLAY_INPUT_SOURCE)
    begin
      sel_one <= WDATA[dswc_pkg::FLD_SRC_ONE_LSB +: 2];
      sel_two <= WDATA[dswc_pkg::FLD_SRC_TWO];
      sel_overlay <= WDATA[dswc_pkg::FLD_SRC_OVERLAY];
    end
  end

  // warp writeback control and buffer address
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      warp_tiled <= dswc_pkg::RST_WARP_WB_CONTROL[dswc_pkg::FLD_WARP_TILED];
      warp_enable <= dswc_pkg::RST_WARP_WB_CONTROL[dswc_pkg::FLD_WARP_WB_ENABLE];
      warp_vflip <= dswc_pkg::RST_WARP_WB_CONTROL[dswc_pkg::FLD_WARP_VFLIP];
      buf0_addr <= dswc_pkg::RST_WARP_WB_BUF0_ADDR;
    end
    else if (WR)
    begin
      unique case (ADDR)
        dswc_pkg::OFS_WARP_WB_CONTROL:
        begin
          warp_tiled <= WDATA[dswc_pkg::FLD_WARP_TILED];
          warp_enable <= WDATA[dswc_pkg::FLD_WARP_WB_ENABLE];
          warp_vflip <= WDATA[dswc_pkg::FLD_WARP_VFLIP];
        end
        dswc_pkg::OFS_WARP_WB_BUF0_ADDR0: buf0_addr[7:0] <= WDATA;
        dswc_pkg::OFS_WARP_WB_BUF0_ADDR1: buf0_addr[15:8] <= WDATA;
        dswc_pkg::OFS_WARP_WB_BUF0_ADDR2: buf0_addr[23:16] <= WDATA;
        dswc_pkg::OFS_WARP_WB_BUF0_ADDR3: buf0_addr[31:24] <= WDATA;
        default: ;
      endcase
    end
  end

  // trigger pulses: one cycle per write of one, nothing is stored
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      WARP_TRIGGER <= 1'b0;
      BLEND_WB_TRIGGER <= 1'b0;
    end
    else
    begin
      WARP_TRIGGER <= WR && ADDR == dswc_pkg::OFS_WARP_WB_CONTROL
        && WDATA[dswc_pkg::FLD_TRIG_WARP];
      BLEND_WB_TRIGGER <= WR && ADDR == dswc_pkg::OFS_WARP_WB_CONTROL
        && WDATA[dswc_pkg::FLD_TRIG_BLEND_WB];
    end
  end

  // ****************************************************************
  // derived outputs
  // ****************************************************************
  assign FETCH_HEIGHT = {height_high, height_low};
  assign FETCH_VWIDTH = {vwidth_high, vwidth_low};

  // bits per pixel of the fetch format; unknown codes fall back to 8
  always_comb
  begin
    unique case (pixel_format)
      dswc_pkg::FMT_RGB888: FETCH_BPP = dswc_pkg::BPP_24;
      dswc_pkg::FMT_RGB565: FETCH_BPP = dswc_pkg::BPP_16;
      default: FETCH_BPP = dswc_pkg::BPP_8;
    endcase
  end

  // stride in bytes; exact only when width times bpp is a multiple of 8
  assign FETCH_STRIDE_BYTES = 17'((22'(FETCH_VWIDTH) * 22'(FETCH_BPP)) >> 3);

  // tiled and flip settings reach the writer only while writeback is enabled; the buffer address always passes
  assign WARP_WB_ENABLE = warp_enable;
  assign WARP_WB_TILED = warp_enable && warp_tiled;
  assign WARP_WB_VFLIP = warp_enable && warp_vflip && !warp_tiled;
  assign WARP_WB_BUF0_ADDR = buf0_addr;
  // the main buffer switch is held off only in the cycle of a blend writeback trigger pulse
  assign MAIN_BUFFER_SWITCH_OK = !BLEND_WB_TRIGGER;

  dswc_source_route u_route (
    .sel_one(sel_one),
    .sel_two(sel_two),
    .sel_overlay(sel_overlay),
    .feed_one(DISPLAY_INPUT_ONE),
    .feed_two(DISPLAY_INPUT_TWO),
    .feed_overlay(OVERLAY_DISPLAY_INPUT),
    .illegal(ROUTE_ILLEGAL)
  );

  // ****************************************************************
  // idle status and interrupts
  // ****************************************************************
  // two-stage synchroniser; busy resets low so flags read idle
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      busy_meta <= 4'h0;
      busy_sync <= 4'h0;
      busy_prev <= 4'h0;
    end
    else
    begin
      busy_meta <= {CAM_TWO_BUSY, CAM_ONE_BUSY, BLEND_WB_BUSY, WARP_WB_BUSY};
      busy_sync <= busy_meta;
      busy_prev <= busy_sync;
    end
  end

  assign frame_done = busy_prev & ~busy_sync;

  // sticky done bits; a new event beats a write-one clear
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      irq_status <= 4'h0;
      irq_mask <= 4'h0;
    end
    else
    begin
      if (WR && ADDR == dswc_pkg::OFS_IRQ_MASK)
        irq_mask <= WDATA[3:0];
      if (WR && ADDR == dswc_pkg::OFS_IRQ_STATUS)
        irq_status <= (irq_status & ~WDATA[3:0]) | frame_done;
      else
        irq_status <= irq_status | frame_done;
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  // ****************************************************************
  // read port
  // ****************************************************************
  assign source_readback = {~busy_sync, sel_overlay, sel_two, sel_one};
  // trigger bits always read zero
  assign control_readback = {warp_tiled, warp_enable, warp_vflip, 5'h00};

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (ADDR)
      dswc_pkg::OFS_FETCH_HEIGHT_LOW: next_rdata = height_low;
      dswc_pkg::OFS_FETCH_HEIGHT_HIGH: next_rdata = {5'h00, height_high};
      dswc_pkg::OFS_FETCH_VWIDTH_LOW: next_rdata = vwidth_low;
      dswc_pkg::OFS_FETCH_VWIDTH_HIGH: next_rdata = {5'h00, vwidth_high};
      dswc_pkg::OFS_FETCH_PIXEL_FORMAT: next_rdata = {5'h00, pixel_format};
      dswc_pkg::OFS_DISPLAY_INPUT_SOURCE: next_rdata = source_readback;
      dswc_pkg::OFS_WARP_WB_CONTROL: next_rdata = control_readback;
      dswc_pkg::OFS_WARP_WB_BUF0_ADDR0: next_rdata = buf0_addr[7:0];
      dswc_pkg::OFS_WARP_WB_BUF0_ADDR1: next_rdata = buf0_addr[15:8];
      dswc_pkg::OFS_WARP_WB_BUF0_ADDR2: next_rdata = buf0_addr[23:16];
      dswc_pkg::OFS_WARP_WB_BUF0_ADDR3: next_rdata = buf0_addr[31:24];
      dswc_pkg::OFS_IRQ_STATUS: next_rdata = {4'h0, irq_status};
      dswc_pkg::OFS_IRQ_MASK: next_rdata = {4'h0, irq_mask};
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      RDATA <= 8'h00;
    else
      RDATA <= RD ? next_rdata : 8'h00;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_height_assembly: assert property (@(posedge SYS_CLK) disable iff (RST)
    (WR && ADDR == dswc_pkg::OFS_FETCH_HEIGHT_HIGH) |=> FETCH_HEIGHT[10:8] == $past(WDATA[2:0]))
    else $error("fetch height high bits not taken from write");
  chk_idle_flags: assert property (@(posedge SYS_CLK) disable iff (RST)
    (RD && ADDR == dswc_pkg::OFS_DISPLAY_INPUT_SOURCE)
      |=> RDATA[7:6] == ~$past(busy_sync[3:2]))
    else $error("camera idle flags wrong");
  chk_wb_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
    (RD && ADDR == dswc_pkg::OFS_DISPLAY_INPUT_SOURCE)
      |=> RDATA[5:4] == ~$past(busy_sync[1:0]))
    else $error("writeback idle flags wrong");
  chk_input_two: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!sel_two) |-> DISPLAY_INPUT_TWO == dswc_pkg::FEED_BLEND_TWO)
    else $error("input two source wrong");
  chk_input_one: assert property (@(posedge SYS_CLK) disable iff (RST)
    (WR && ADDR == dswc_pkg::OFS_DISPLAY_INPUT_SOURCE && WDATA[1:0] == 2'b01)
      |=> DISPLAY_INPUT_ONE == dswc_pkg::FEED_WARP)
    else $error("input one not warp");
  chk_vflip_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    !warp_enable |-> !WARP_WB_VFLIP && !WARP_WB_TILED)
    else $error("writeback settings leak while disabled");
  // exactly one pulse per accepted write of one, none otherwise
  chk_warp_trigger: assert property (@(posedge SYS_CLK) disable iff (RST)
    !$past(RST) |-> WARP_TRIGGER == $past(WR && ADDR == dswc_pkg::OFS_WARP_WB_CONTROL
      && WDATA[dswc_pkg::FLD_TRIG_WARP]))
    else $error("warp trigger not one pulse per write");
  chk_blend_trigger: assert property (@(posedge SYS_CLK) disable iff (RST)
    BLEND_WB_TRIGGER |-> $past(WR && ADDR == dswc_pkg::OFS_WARP_WB_CONTROL && WDATA[3]))
    else $error("blend trigger without a write");
  chk_trigger_reads: assert property (@(posedge SYS_CLK) disable iff (RST)
    $past(RD && ADDR == dswc_pkg::OFS_WARP_WB_CONTROL) |-> RDATA[4:3] == 2'b00)
    else $error("trigger bits read nonzero");
endmodule : dswc_config
`default_nettype wire

//--- hw/dswc_pkg.sv
// package: offsets, fields, reset values and codes for the source and writeback config block
package dswc_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_FETCH_HEIGHT_LOW = 12'h9c2;
  localparam logic [11:0] OFS_FETCH_HEIGHT_HIGH = 12'h9c3;
  localparam logic [11:0] OFS_FETCH_VWIDTH_LOW = 12'h9c4;
  localparam logic [11:0] OFS_FETCH_VWIDTH_HIGH = 12'h9c5;
  localparam logic [11:0] OFS_FETCH_PIXEL_FORMAT = 12'h9c6;
  localparam logic [11:0] OFS_DISPLAY_INPUT_SOURCE = 12'h9c8;
  localparam logic [11:0] OFS_WARP_WB_CONTROL = 12'h9ca;
  localparam logic [11:0] OFS_WARP_WB_BUF0_ADDR0 = 12'h9d0;
  localparam logic [11:0] OFS_WARP_WB_BUF0_ADDR1 = 12'h9d1;
  localparam logic [11:0] OFS_WARP_WB_BUF0_ADDR2 = 12'h9d2;
  localparam logic [11:0] OFS_WARP_WB_BUF0_ADDR3 = 12'h9d3;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h9e0;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h9e1;
  // reset values
  localparam logic [7:0] RST_FETCH_HEIGHT_LOW = 8'hf0;
  localparam logic [7:0] RST_FETCH_HEIGHT_HIGH = 8'h00;
  localparam logic [7:0] RST_FETCH_VWIDTH_LOW = 8'h40;
  localparam logic [7:0] RST_FETCH_VWIDTH_HIGH = 8'h01;
  localparam logic [7:0] RST_FETCH_PIXEL_FORMAT = 8'h00;
  localparam logic [7:0] RST_DISPLAY_INPUT_SOURCE = 8'h00;
  localparam logic [7:0] RST_WARP_WB_CONTROL = 8'h00;
  localparam logic [31:0] RST_WARP_WB_BUF0_ADDR = 32'h1000_0000;
  // field positions
  localparam int FLD_HEIGHT_HIGH_MSB = 2;
  localparam int FLD_VWIDTH_HIGH_MSB = 2;
  localparam int FLD_SRC_ONE_LSB = 0;
  localparam int FLD_SRC_TWO = 2;
  localparam int FLD_SRC_OVERLAY = 3;
  localparam int FLD_IDLE_WARP = 4;
  localparam int FLD_IDLE_BLEND_WB = 5;
  localparam int FLD_IDLE_CAM_ONE = 6;
  localparam int FLD_IDLE_CAM_TWO = 7;
  localparam int FLD_TRIG_BLEND_WB = 3;
  localparam int FLD_TRIG_WARP = 4;
  localparam int FLD_WARP_VFLIP = 5;
  localparam int FLD_WARP_WB_ENABLE = 6;
  localparam int FLD_WARP_TILED = 7;
  // interrupt status bits: writer finished a frame
  localparam int IRQ_CAM_TWO_DONE = 3;
  localparam int IRQ_CAM_ONE_DONE = 2;
  localparam int IRQ_BLEND_WB_DONE = 1;
  localparam int IRQ_WARP_DONE = 0;
  // sources of display input one
  typedef enum logic [1:0] {
    SRC_BLEND_ONE = 2'b00,
    SRC_WARP = 2'b01,
    SRC_FETCHER = 2'b10,
    SRC_RESERVED = 2'b11
  } dswc_src_one_t;
  // sources seen on a display input
  typedef enum logic [2:0] {
    FEED_BLEND_ONE = 3'h0,
    FEED_BLEND_TWO = 3'h1,
    FEED_BLEND_OVERLAY = 3'h2,
    FEED_WARP = 3'h3,
    FEED_FETCHER = 3'h4,
    FEED_NONE = 3'h7
  } dswc_feed_t;
  // fetch pixel format codes
  localparam logic [2:0] FMT_RGB332 = 3'b000;
  localparam logic [2:0] FMT_RGB565 = 3'b001;
  localparam logic [2:0] FMT_RGB888 = 3'b010;
  localparam logic [4:0] BPP_8 = 5'h08;
  localparam logic [4:0] BPP_16 = 5'h10;
  localparam logic [4:0] BPP_24 = 5'h18;
endpackage : dswc_pkg

//--- hw/dswc_source_route.sv
// source routing of the three display inputs from the blend engine, warp and fetcher
`timescale 1ns/1ps
`default_nettype none
module dswc_source_route (
  // selections
  input wire logic [1:0] sel_one,
  input wire logic sel_two,
  input wire logic sel_overlay,
  // resulting feeds
  output dswc_pkg::dswc_feed_t feed_one,
  output dswc_pkg::dswc_feed_t feed_two,
  output dswc_pkg::dswc_feed_t feed_overlay,
  output logic illegal
);
  logic one_uses_blend;

  // input one picks among blend one, warp and fetcher
  always_comb
  begin
    unique case (sel_one)
      2'b00: feed_one = dswc_pkg::FEED_BLEND_ONE;
      2'b01: feed_one = dswc_pkg::FEED_WARP;
      2'b10: feed_one = dswc_pkg::FEED_FETCHER;
      default: feed_one = dswc_pkg::FEED_NONE;
    endcase
  end

  assign one_uses_blend = (sel_one == 2'b00);
  // blend one may reach only one input; a clash blanks the extra input
  assign feed_two = !sel_two ? dswc_pkg::FEED_BLEND_TWO :
    (one_uses_blend ? dswc_pkg::FEED_NONE : dswc_pkg::FEED_BLEND_ONE);
  assign feed_overlay = !sel_overlay ? dswc_pkg::FEED_BLEND_OVERLAY :
    ((one_uses_blend || sel_two) ? dswc_pkg::FEED_NONE : dswc_pkg::FEED_BLEND_ONE);
  assign illegal = (sel_one == 2'b11) || (sel_two && (one_uses_blend || sel_overlay))
    || (sel_overlay && one_uses_blend);
endmodule : dswc_source_route
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the display source and warp writeback config bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic sys_clk;
  logic rst;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [7:0] rdata;
  logic cam_one_busy, cam_two_busy, blend_wb_busy, warp_wb_busy;
  logic [10:0] fetch_height, fetch_vwidth;
  logic [4:0] fetch_bpp;
  logic [16:0] fetch_stride;
  dswc_pkg::dswc_feed_t in_one, in_two, in_ovl;
  logic route_illegal, wb_en, wb_tiled, wb_vflip, warp_trig, blend_trig, switch_ok, irq;
  logic [31:0] buf0_addr;
  int fail_count;
  int comparisons;

  dswc_config i_dut (
    .SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .CAM_ONE_BUSY(cam_one_busy), .CAM_TWO_BUSY(cam_two_busy),
    .BLEND_WB_BUSY(blend_wb_busy), .WARP_WB_BUSY(warp_wb_busy),
    .FETCH_HEIGHT(fetch_height), .FETCH_VWIDTH(fetch_vwidth), .FETCH_BPP(fetch_bpp),
    .FETCH_STRIDE_BYTES(fetch_stride), .DISPLAY_INPUT_ONE(in_one),
    .DISPLAY_INPUT_TWO(in_two), .OVERLAY_DISPLAY_INPUT(in_ovl),
    .ROUTE_ILLEGAL(route_illegal), .WARP_WB_ENABLE(wb_en), .WARP_WB_TILED(wb_tiled),
    .WARP_WB_VFLIP(wb_vflip), .WARP_WB_BUF0_ADDR(buf0_addr), .WARP_TRIGGER(warp_trig),
    .BLEND_WB_TRIGGER(blend_trig), .MAIN_BUFFER_SWITCH_OK(switch_ok), .IRQ(irq)
  );

  // 50 ns clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // bus cycles and comparison
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one-cycle write strobe; returns at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe, so it is sampled there
  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1;
    chk({24'h0, rdata}, {24'h0, exp}, what);
  endtask : rdchk

  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask : settle

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rdchk(12'h9c2, 8'hf0, "height low reset");
    rdchk(12'h9c3, 8'h00, "height high reset");
    rdchk(12'h9c4, 8'h40, "vwidth low reset");
    rdchk(12'h9c5, 8'h01, "vwidth high reset");
    rdchk(12'h9c8, 8'hf0, "idle flags and routing reset");
    rdchk(12'h9ca, 8'h00, "warp control reset");
    rdchk(12'h9d3, 8'h10, "addr byte3 reset");
    rdchk(12'h9d1, 8'h00, "addr byte1 reset");
    wr(12'h9c7, 8'hff);
    rdchk(12'h9c7, 8'h00, "unmapped place reads zero");
    chk(buf0_addr, 32'h1000_0000, "buffer address reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_geometry();
    wr(12'h9c3, 8'hff);
    rdchk(12'h9c3, 8'h07, "height high upper bits ignored");
    wr(12'h9c2, 8'h00);
    settle();
    chk(fetch_height, 11'h700, "fetch height assembled");
    for (int f = 0; f < 3; f++)
    begin
      wr(12'h9c6, f[7:0]);
      settle();
      chk(fetch_bpp, 5'd8 * (f + 1), "bpp from pixel format");
      chk(fetch_stride, 17'd40 * (f + 1) * 8, "stride from virtual width");
    end
    chk(fetch_vwidth, 11'h140, "virtual width from reset bytes");
    // 64 pixels at 24 bpp keeps the line a whole number of 64-bit words
    wr(12'h9c5, 8'hf8);
    wr(12'h9c4, 8'h40);
    settle();
    chk(fetch_vwidth, 11'h040, "virtual width upper bits ignored");
    chk(fetch_stride, 17'd192, "stride of 64 pixels at 24 bpp");
    $display("test geometry done");
  endtask : t_geometry

  task automatic t_idle_irq();
    @(posedge sys_clk);
    {cam_two_busy, cam_one_busy, blend_wb_busy, warp_wb_busy} <= 4'hf;
    repeat (4) @(posedge sys_clk);
    rdchk(12'h9c8, 8'h00, "all writers busy");
    {cam_two_busy, cam_one_busy, blend_wb_busy, warp_wb_busy} <= 4'h0;
    repeat (4) @(posedge sys_clk);
    rdchk(12'h9c8, 8'hf0, "all writers idle again");
    rdchk(12'h9e0, 8'h0f, "frame done status set");
    chk(irq, 1'b0, "masked events keep irq low");
    wr(12'h9e1, 8'h04);
    settle();
    chk(irq, 1'b1, "unmasked status raises irq");
    wr(12'h9e0, 8'h04);
    settle();
    chk(irq, 1'b0, "cleared status drops irq");
    rdchk(12'h9e0, 8'h0b, "one-to-clear leaves others");
    wr(12'h9e0, 8'h0f);
    rdchk(12'h9e0, 8'h00, "status fully cleared");
    $display("test idle and interrupt done");
  endtask : t_idle_irq

  task automatic t_routing();
    logic [3:0] c;
    logic bad;
    dswc_pkg::dswc_feed_t e1;
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      // blend one may serve only one input; code 3 is reserved
      bad = (c[1:0] == 2'b11) || (c[1:0] == 2'b00 && (c[2] || c[3])) || (c[2] && c[3]);
      e1 = (c[1:0] == 2'b00) ? dswc_pkg::FEED_BLEND_ONE :
           (c[1:0] == 2'b01) ? dswc_pkg::FEED_WARP : dswc_pkg::FEED_FETCHER;
      wr(12'h9c8, {4'h0, c});
      settle();
      chk(route_illegal, bad, "route clash flag");
      if (!bad)
      begin
        chk(in_one, e1, "input one source");
        chk(in_two, c[2] ? dswc_pkg::FEED_BLEND_ONE : dswc_pkg::FEED_BLEND_TWO, "input two");
        chk(in_ovl, c[3] ? dswc_pkg::FEED_BLEND_ONE : dswc_pkg::FEED_BLEND_OVERLAY, "overlay");
      end
      if (c[1:0] == 2'b11)
        chk(in_one, dswc_pkg::FEED_NONE, "reserved code blanks input one");
      rdchk(12'h9c8, {4'hf, c}, "routing read back");
    end
    wr(12'h9c8, 8'h00);
    $display("test routing done");
  endtask : t_routing

  task automatic t_warp();
    wr(12'h9ca, 8'h60);
    settle();
    chk({wb_en, wb_tiled, wb_vflip}, 3'b101, "flip applied while enabled");
    wr(12'h9ca, 8'he0);
    settle();
    chk({wb_en, wb_tiled, wb_vflip}, 3'b110, "flip held off in tiled mode");
    wr(12'h9ca, 8'hc0);
    settle();
    chk({wb_en, wb_tiled, wb_vflip}, 3'b110, "tiled mode with flip kept off");
    wr(12'h9ca, 8'ha0);
    settle();
    chk({wb_en, wb_tiled, wb_vflip}, 3'b000, "settings ignored while disabled");
    wr(12'h9ca, 8'hf8);
    #1;
    chk({warp_trig, blend_trig, switch_ok}, 3'b110, "both triggers pulse");
    settle();
    chk({warp_trig, blend_trig, switch_ok}, 3'b001, "triggers last one cycle");
    rdchk(12'h9ca, 8'he0, "trigger bits read zero");
    wr(12'h9ca, 8'h00);
    #1;
    chk({warp_trig, blend_trig}, 2'b00, "writing zero starts nothing");
    wr(12'h9ca, 8'h10);
    #1;
    chk(warp_trig, 1'b1, "first warp trigger");
    wr(12'h9ca, 8'h10);
    #1;
    chk(warp_trig, 1'b1, "second warp trigger");
    settle();
    chk(warp_trig, 1'b0, "one pulse per write");
    $display("test warp writeback done");
  endtask : t_warp

  task automatic t_address();
    logic [31:0] v;
    v = 32'h7856_3408;
    for (int b = 0; b < 4; b++)
      wr(12'h9d0 + b[11:0], v[8*b +: 8]);
    settle();
    chk(buf0_addr, v, "buffer 0 start address");
    for (int b = 0; b < 4; b++)
      rdchk(12'h9d0 + b[11:0], v[8*b +: 8], "address byte read back");
    $display("test address done");
  endtask : t_address

  // ************************************************************
  // verdict
  // ************************************************************
  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #200000;
    fail_count++;
    $display("[FAIL] %0t watchdog ran out", $time);
    close_out();
  end

  // main sequence
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    rst = 1'b1;
    addr = 12'h000;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    {cam_one_busy, cam_two_busy, blend_wb_busy, warp_wb_busy} = 4'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_geometry();
    t_idle_irq();
    t_routing();
    t_warp();
    t_address();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
